// ---- core/bsc_station_io.sv ----
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
// Operation
// - Local keyup low keys transmitter with local receiver audio as source.
// - Remote keyup low keys transmitter with remote audio as source.
// - Modulation select high routes high-speed data, low routes low-speed data and voice.
// - Limiter select high gives high time constant, low gives low one.
// - Receiver mute low blocks receiver audio to transmitter and line output.
// - Mute during high-speed transmit, without carrier, or without valid low-speed data.
// - Two low-speed outputs form a two-bit Walsh level generator.
// - Loader data changes so the synthesizer samples on the clock falling edge.
// - Loader clock and data run at about 2.4 kbit/s.
// - Loader clock and data only move while load enable is high.
// - After a load, lock input high confirms success.
// - Lock is watched continuously; losing it is a failure. The code flags lock loss only while the loader is idle.
// - Power-amp failure input high means a failed amplifier.
// - Floating power-amp failure line reads as failure through its pull-up.
// - Remote-audio flag low means tone or signalling from the dispatch link.
// - Frame-sync line driven as control channel, sampled as working channel.
// - Monitor input is digitised to eight bits.
// - Mode changes only on control-channel failure or configuration command.
// - Control-channel unit may also change mode on carrier detection.
module bsc_station_io #(
    parameter int HALF_BIT = bsc_pkg::HALF_BIT_CYC,
    parameter int WORD_W   = 32
) (
    // Clock and reset
    input  wire logic                     I_CLK,
    input  wire logic                     I_RST_N,
    // APB slave
    input  wire logic                     I_PSEL,
    input  wire logic                     I_PENABLE,
    input  wire logic                     I_PWRITE,
    input  wire logic [7:0]               I_PADDR,
    input  wire logic [31:0]              I_PWDATA,
    output logic [31:0]                   O_PRDATA,
    output logic                          O_PREADY,
    output logic                          O_PSLVERR,
    // Station inputs
    input  wire bsc_pkg::bsc_station_in_t I_STATION,
    input  wire logic [7:0]               I_MONITOR_ADC_CODE,
    // Station outputs
    output logic                          O_LOCAL_KEYUP_N,
    output logic                          O_REMOTE_KEYUP_N,
    output logic                          O_HIGH_SPEED_DATA_SEL,
    output logic                          O_LIMITER_TIME_CONSTANT_SEL,
    output logic                          O_RECEIVER_AUDIO_MUTE_N,
    output logic [1:0]                    O_WALSH_LEVEL,
    output bsc_pkg::bsc_loader_out_t      O_LOADER,
    output logic [1:0]                    O_MODE,
    // Frame-sync line, open drain
    input  wire logic                     I_FRAME_SYNC_LINE,
    output logic                          O_FRAME_SYNC_LINE,
    output logic                          O_FRAME_SYNC_LINE_OE
);
    import bsc_pkg::*;

    typedef enum logic [2:0] {LD_IDLE, LD_SETUP, LD_LOW, LD_HIGH, LD_HOLD, LD_CHECK} bsc_ld_state_t;

    bsc_station_in_t      st_meta_reg;
    bsc_station_in_t      st_reg;
    logic                 fsl_meta_reg;
    logic                 fsl_reg;
    logic [7:0]           adc_meta_reg;
    logic [7:0]           adc_reg;
    logic [CTRL_W-1:0]    ctrl_reg;
    logic [1:0]           mode_reg;
    logic [1:0]           car_mode_reg;
    logic [1:0]           fb_mode_reg;
    logic [WORD_W-1:0]    word_reg;
    logic [WORD_W-1:0]    shift_reg;
    logic [CMD_LEN_W-1:0] bits_left_reg;
    logic [15:0]          tmr_reg;
    bsc_ld_state_t        ld_state_reg;
    logic                 en_reg;
    logic                 sclk_reg;
    logic                 sdata_reg;
    logic                 done_reg;
    logic                 ld_fail_reg;
    logic                 lock_lost_reg;
    logic                 cc_fail_reg;
    logic                 lock_prev_reg;
    logic                 pa_prev_reg;
    logic                 unsq_prev_reg;
    logic                 mute_n_reg;
    logic                 wr;
    logic                 rd;
    logic                 mapped;
    logic                 tmr_zero;
    logic                 start;
    logic                 check_end;
    logic                 lock_loss_ev;
    logic                 cc_fail_ev;
    logic                 carrier_ev;
    logic                 cfg_cmd;
    logic                 transmit;
    logic                 mute_cond;
    logic [31:0]          status_word;

    // Synchronisers for every pin input
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            st_meta_reg  <= '0;
            st_reg       <= '0;
            fsl_meta_reg <= 1'b1;
            fsl_reg      <= 1'b1;
            adc_meta_reg <= 8'h00;
            adc_reg      <= 8'h00;
        end else begin
            st_meta_reg  <= I_STATION;
            st_reg       <= st_meta_reg;
            fsl_meta_reg <= I_FRAME_SYNC_LINE;
            fsl_reg      <= fsl_meta_reg;
            adc_meta_reg <= I_MONITOR_ADC_CODE;
            adc_reg      <= adc_meta_reg;
        end
    end

    // APB decode; zero wait states, so pready stays high
    assign wr       = I_PSEL && I_PENABLE && I_PWRITE;
    assign rd       = I_PSEL && I_PENABLE && !I_PWRITE;
    assign mapped   = (I_PADDR == CTRL_OFS) || (I_PADDR == MODE_OFS) || (I_PADDR == WORD_OFS)
                   || (I_PADDR == CMD_OFS) || (I_PADDR == STATUS_OFS) || (I_PADDR == ADC_OFS);
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

    // Status view of pins and loader
    always_comb begin
        status_word              = 32'h0000_0000;
        status_word[ST_UNSQ]     = st_reg.receiver_unsquelch_in;
        status_word[ST_PA_FAIL]  = st_reg.power_amp_failure_in;
        status_word[ST_REM_AUD]  = !st_reg.remote_audio_present_n;
        status_word[ST_LOCK]     = st_reg.freq_lock_in;
        status_word[ST_FSL_IN]   = fsl_reg;
        status_word[ST_BUSY]     = (ld_state_reg != LD_IDLE);
        status_word[ST_DONE]     = done_reg;
        status_word[ST_LD_FAIL]  = ld_fail_reg;
        status_word[ST_LOCK_LOS] = lock_lost_reg;
        status_word[ST_CC_FAIL]  = cc_fail_reg;
    end

    // Registered read data; unmapped reads give zero
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_PRDATA <= 32'h0000_0000;
        end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            unique case (I_PADDR)
                CTRL_OFS:   O_PRDATA <= {21'h0, ctrl_reg};
                MODE_OFS:   O_PRDATA <= {26'h0, fb_mode_reg, car_mode_reg, mode_reg};
                WORD_OFS:   O_PRDATA <= word_reg;
                STATUS_OFS: O_PRDATA <= status_word;
                ADC_OFS:    O_PRDATA <= {24'h000000, adc_reg};
                default:    O_PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Control and loader word registers
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            ctrl_reg <= CTRL_RST;
            word_reg <= '0;
        end else if (wr) begin
            if (I_PADDR == CTRL_OFS)
                ctrl_reg <= I_PWDATA[CTRL_W-1:0];
            if (I_PADDR == WORD_OFS)
                word_reg <= I_PWDATA[WORD_W-1:0];
        end
    end

    // Station outputs straight from control bits
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_LOCAL_KEYUP_N             <= 1'b1;
            O_REMOTE_KEYUP_N            <= 1'b1;
            O_HIGH_SPEED_DATA_SEL       <= 1'b0;
            O_LIMITER_TIME_CONSTANT_SEL <= 1'b0;
            O_WALSH_LEVEL               <= 2'h0;
        end else begin
            O_LOCAL_KEYUP_N             <= !ctrl_reg[CTRL_LOC_KEY];
            O_REMOTE_KEYUP_N            <= !ctrl_reg[CTRL_REM_KEY];
            O_HIGH_SPEED_DATA_SEL       <= ctrl_reg[CTRL_HS_SEL];
            O_LIMITER_TIME_CONSTANT_SEL <= ctrl_reg[CTRL_LIM_SEL];
            O_WALSH_LEVEL               <= ctrl_reg[CTRL_WALSH_LO +: 2];
        end
    end

    // Mute whenever any audio source is untrustworthy
    assign transmit  = ctrl_reg[CTRL_LOC_KEY] || ctrl_reg[CTRL_REM_KEY];
    assign mute_cond = (transmit && ctrl_reg[CTRL_HS_SEL]) || !st_reg.receiver_unsquelch_in
                    || !ctrl_reg[CTRL_LSD_OK] || ctrl_reg[CTRL_FORCE_MUT];
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N)
            mute_n_reg <= 1'b0;
        else
            mute_n_reg <= !mute_cond;
    end
    assign O_RECEIVER_AUDIO_MUTE_N = mute_n_reg;

    // Frame sync: drive only as control channel, release otherwise
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_FRAME_SYNC_LINE    <= 1'b0;
            O_FRAME_SYNC_LINE_OE <= 1'b1;
        end else begin
            O_FRAME_SYNC_LINE    <= 1'b0;
            O_FRAME_SYNC_LINE_OE <= !(ctrl_reg[CTRL_ROLE_CC] && !ctrl_reg[CTRL_FSL_LVL]);
        end
    end

    // Loader sequencer
    assign tmr_zero  = (tmr_reg == 16'h0000);
    assign start     = wr && (I_PADDR == CMD_OFS) && I_PWDATA[CMD_START];
    assign check_end = (ld_state_reg == LD_CHECK) && tmr_zero;
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            ld_state_reg  <= LD_IDLE;
            tmr_reg       <= 16'h0000;
            en_reg        <= 1'b0;
            sclk_reg      <= 1'b0;
            sdata_reg     <= 1'b0;
            shift_reg     <= '0;
            bits_left_reg <= '0;
        end else begin
            if (!tmr_zero)
                tmr_reg <= tmr_reg - 16'h0001;
            unique case (ld_state_reg)
                LD_IDLE: begin
                    if (start && (I_PWDATA[CMD_LEN_LO +: CMD_LEN_W] != '0)) begin
                        en_reg        <= 1'b1;
                        shift_reg     <= word_reg;
                        bits_left_reg <= I_PWDATA[CMD_LEN_LO +: CMD_LEN_W];
                        tmr_reg       <= 16'(HALF_BIT - 1);
                        ld_state_reg  <= LD_SETUP;
                    end
                end
                LD_SETUP, LD_LOW: begin
                    if (tmr_zero) begin
                        // New bit placed at the rising edge, stable through the high half
                        sclk_reg      <= 1'b1;
                        sdata_reg     <= shift_reg[0];
                        shift_reg     <= shift_reg >> 1;
                        bits_left_reg <= bits_left_reg - 1'b1;
                        tmr_reg       <= 16'(HALF_BIT - 1);
                        ld_state_reg  <= LD_HIGH;
                    end
                end
                LD_HIGH: begin
                    if (tmr_zero) begin
                        sclk_reg     <= 1'b0;
                        tmr_reg      <= 16'(HALF_BIT - 1);
                        ld_state_reg <= (bits_left_reg == '0) ? LD_HOLD : LD_LOW;
                    end
                end
                LD_HOLD: begin
                    if (tmr_zero) begin
                        en_reg       <= 1'b0;
                        sdata_reg    <= 1'b0;
                        tmr_reg      <= 16'(HALF_BIT - 1);
                        ld_state_reg <= LD_CHECK;
                    end
                end
                LD_CHECK: begin
                    if (tmr_zero)
                        ld_state_reg <= LD_IDLE;
                end
            endcase
        end
    end
    assign O_LOADER.freq_loader_enable = en_reg;
    assign O_LOADER.freq_loader_clk    = sclk_reg;
    assign O_LOADER.freq_loader_data   = sdata_reg;

    // Lock watch outside loads; a reload may briefly unlock the loop
    assign lock_loss_ev = lock_prev_reg && !st_reg.freq_lock_in && (ld_state_reg == LD_IDLE);
    assign cc_fail_ev   = ctrl_reg[CTRL_ROLE_CC]
                       && (lock_loss_ev || (st_reg.power_amp_failure_in && !pa_prev_reg));
    assign carrier_ev   = ctrl_reg[CTRL_ROLE_CC] && ctrl_reg[CTRL_CAR_SW]
                       && st_reg.receiver_unsquelch_in && !unsq_prev_reg;
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            lock_prev_reg <= 1'b0;
            pa_prev_reg   <= 1'b1;
            unsq_prev_reg <= 1'b0;
        end else begin
            lock_prev_reg <= st_reg.freq_lock_in;
            pa_prev_reg   <= st_reg.power_amp_failure_in;
            unsq_prev_reg <= st_reg.receiver_unsquelch_in;
        end
    end

    // Sticky flags, write one to clear; a new event beats the clear
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            done_reg      <= 1'b0;
            ld_fail_reg   <= 1'b0;
            lock_lost_reg <= 1'b0;
            cc_fail_reg   <= 1'b0;
        end else begin
            done_reg      <= (check_end && st_reg.freq_lock_in)
                          || (done_reg && !(wr && I_PADDR == STATUS_OFS && I_PWDATA[ST_DONE]));
            ld_fail_reg   <= (check_end && !st_reg.freq_lock_in)
                          || (ld_fail_reg && !(wr && I_PADDR == STATUS_OFS && I_PWDATA[ST_LD_FAIL]));
            lock_lost_reg <= lock_loss_ev
                          || (lock_lost_reg && !(wr && I_PADDR == STATUS_OFS && I_PWDATA[ST_LOCK_LOS]));
            cc_fail_reg   <= cc_fail_ev
                          || (cc_fail_reg && !(wr && I_PADDR == STATUS_OFS && I_PWDATA[ST_CC_FAIL]));
        end
    end

    // Operating mode; failure outranks carrier, both outrank software
    assign cfg_cmd = wr && (I_PADDR == MODE_OFS);
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            mode_reg     <= MODE_RST;
            car_mode_reg <= MODE_RST;
            fb_mode_reg  <= MODE_RST;
        end else begin
            if (cfg_cmd) begin
                car_mode_reg <= I_PWDATA[MODE_CAR_LO +: 2];
                fb_mode_reg  <= I_PWDATA[MODE_FB_LO +: 2];
            end
            if (cc_fail_ev)
                mode_reg <= fb_mode_reg;
            else if (carrier_ev)
                mode_reg <= car_mode_reg;
            else if (cfg_cmd)
                mode_reg <= I_PWDATA[MODE_CUR_LO +: 2];
        end
    end
    assign O_MODE = mode_reg;

    // Checks on the station behaviour
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    property p_clk_guard;
        sclk_reg |-> en_reg;
    endproperty
    a_clk_guard: assert property (p_clk_guard) else $error("loader clock high without enable");

    property p_data_stable;
        sclk_reg && $past(sclk_reg) |-> $stable(sdata_reg);
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("loader data moved in high half");

    property p_check_disabled;
        (ld_state_reg == LD_CHECK) |-> !en_reg && !sclk_reg;
    endproperty
    a_check_disabled: assert property (p_check_disabled) else $error("lock sampled with enable high");

    property p_load_result;
        check_end |=> (done_reg || ld_fail_reg) && (ld_state_reg == LD_IDLE);
    endproperty
    a_load_result: assert property (p_load_result) else $error("load result not flagged");

    property p_lock_lost;
        lock_loss_ev |=> lock_lost_reg;
    endproperty
    a_lock_lost: assert property (p_lock_lost) else $error("lock loss not flagged");

    property p_mute;
        mute_cond |=> !O_RECEIVER_AUDIO_MUTE_N;
    endproperty
    a_mute: assert property (p_mute) else $error("audio not muted");

    property p_keyup;
        ctrl_reg[CTRL_LOC_KEY] && $stable(ctrl_reg) |=> !O_LOCAL_KEYUP_N;
    endproperty
    a_keyup: assert property (p_keyup) else $error("local keyup not driven");

    property p_fsl_role;
        !ctrl_reg[CTRL_ROLE_CC] |=> O_FRAME_SYNC_LINE_OE;
    endproperty
    a_fsl_role: assert property (p_fsl_role) else $error("frame sync driven as working channel");

    property p_mode_cause;
        !cfg_cmd && !cc_fail_ev && !carrier_ev |=> $stable(mode_reg);
    endproperty
    a_mode_cause: assert property (p_mode_cause) else $error("mode changed without cause");

    property p_pa_status;
        ctrl_reg[CTRL_ROLE_CC] && st_reg.power_amp_failure_in && !pa_prev_reg |=> cc_fail_reg;
    endproperty
    a_pa_status: assert property (p_pa_status) else $error("amp failure not reported");

    c_load_ok: cover property (check_end && st_reg.freq_lock_in);
    c_load_bad: cover property (check_end && !st_reg.freq_lock_in);
    c_carrier_sw: cover property (carrier_ev);
    c_cc_fail: cover property (cc_fail_ev);
endmodule : bsc_station_io

// ---- include/bsc_pkg.sv ----
package bsc_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] MODE_OFS   = 8'h04;
    localparam logic [7:0] WORD_OFS   = 8'h08;
    localparam logic [7:0] CMD_OFS    = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] ADC_OFS    = 8'h14;
    // Control register fields
    localparam int CTRL_LOC_KEY   = 0;
    localparam int CTRL_REM_KEY   = 1;
    localparam int CTRL_HS_SEL    = 2;
    localparam int CTRL_LIM_SEL   = 3;
    localparam int CTRL_LSD_OK    = 4;
    localparam int CTRL_ROLE_CC   = 5;
    localparam int CTRL_FSL_LVL   = 6;
    localparam int CTRL_CAR_SW    = 7;
    localparam int CTRL_WALSH_LO  = 8;
    localparam int CTRL_FORCE_MUT = 10;
    localparam int CTRL_W         = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
    // Mode register fields
    localparam int MODE_CUR_LO = 0;
    localparam int MODE_CAR_LO = 2;
    localparam int MODE_FB_LO  = 4;
    localparam logic [1:0] MODE_RST = 2'h0;
    // Loader command fields
    localparam int CMD_START  = 0;
    localparam int CMD_LEN_LO = 8;
    localparam int CMD_LEN_W  = 6;
    // Status register fields
    localparam int ST_UNSQ     = 0;
    localparam int ST_PA_FAIL  = 1;
    localparam int ST_REM_AUD  = 2;
    localparam int ST_LOCK     = 3;
    localparam int ST_FSL_IN   = 4;
    localparam int ST_BUSY     = 5;
    localparam int ST_DONE     = 6;
    localparam int ST_LD_FAIL  = 7;
    localparam int ST_LOCK_LOS = 8;
    localparam int ST_CC_FAIL  = 9;
    // Loader timing
    localparam int CLK_HZ       = 50_000_000;
    localparam int LOAD_BAUD    = 2400;
    localparam int HALF_BIT_CYC = CLK_HZ / (2 * LOAD_BAUD);

    // Station status pins, raw from the radio
    typedef struct packed {
        logic receiver_unsquelch_in;
        logic power_amp_failure_in;
        logic remote_audio_present_n;
        logic freq_lock_in;
    } bsc_station_in_t;

    // Loader pins toward the synthesizer
    typedef struct packed {
        logic freq_loader_enable;
        logic freq_loader_clk;
        logic freq_loader_data;
    } bsc_loader_out_t;
endpackage : bsc_pkg

// ---- tb/bsc_radio_model.sv ----
`timescale 1ns/100ps
module bsc_radio_model import bsc_pkg::*; (
    // Bench side
    input  wire logic            i_clk,
    input  wire logic            i_car,
    input  wire logic            i_pa_float,
    input  wire logic            i_rem_aud,
    input  wire logic            i_lock_ok,
    // Controller side
    input  wire bsc_loader_out_t i_ld,
    output bsc_station_in_t      o_st,
    output logic [31:0]          o_rx_word,
    output int                   o_rx_cnt,
    output int                   o_en_cyc
);
    logic clk_q = 1'b0;
    logic en_q  = 1'b0;
    // Status pins; an open PA line is pulled high
    assign o_st.receiver_unsquelch_in  = i_car;
    assign o_st.power_amp_failure_in   = i_pa_float;
    assign o_st.remote_audio_present_n = !i_rem_aud;
    // Lock drops while loading, the synthesizer retunes
    assign o_st.freq_lock_in = i_lock_ok & !i_ld.freq_loader_enable;
    // Bits taken on clock fall, only while enabled
    always @(posedge i_clk) begin
        clk_q <= i_ld.freq_loader_clk;
        en_q  <= i_ld.freq_loader_enable;
        if (i_ld.freq_loader_enable && !en_q) begin
            o_en_cyc <= 1;
            o_rx_cnt <= 0;
        end else if (i_ld.freq_loader_enable) begin
            o_en_cyc <= o_en_cyc + 1;
            if (clk_q && !i_ld.freq_loader_clk) begin
                o_rx_word <= {i_ld.freq_loader_data, o_rx_word[31:1]};
                o_rx_cnt  <= o_rx_cnt + 1;
            end
        end
    end
endmodule : bsc_radio_model

// ---- tb/test_base_station_control_io.sv ----
`timescale 1ns/100ps
module test_base_station_control_io;
    import bsc_pkg::*;
    localparam int H = 4;
    logic            clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic            car = 1'b1, paf = 1'b0, rau = 1'b0, lok = 1'b1, pull = 1'b0;
    logic            rdy, err, loc_n, rem_n, hs, lim, mute_n, fo, foe, frame_sync_line;
    logic [1:0]      walsh, mode;
    logic [7:0]      paddr = 8'h00, adc = 8'h00;
    logic [31:0]     pwd = 32'h0, prd, word, c, rxw;
    logic [32:0]     exp_q[$], msk_q[$];
    bsc_station_in_t st;
    bsc_loader_out_t ld;
    int              rxc, enc, n, error_cnt = 0, n_tests = 0;
    integer          seed = 32'hDE737691;
    // Open-drain wire: released means pulled high
    assign frame_sync_line = (foe | fo) & !pull;
    always #10 clk = ~clk;
    bsc_station_io #(.HALF_BIT(H)) i_dut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err),
        .I_STATION(st), .I_MONITOR_ADC_CODE(adc), .O_LOCAL_KEYUP_N(loc_n),
        .O_REMOTE_KEYUP_N(rem_n), .O_HIGH_SPEED_DATA_SEL(hs), .O_LIMITER_TIME_CONSTANT_SEL(lim),
        .O_RECEIVER_AUDIO_MUTE_N(mute_n), .O_WALSH_LEVEL(walsh), .O_LOADER(ld), .O_MODE(mode),
        .I_FRAME_SYNC_LINE(frame_sync_line), .O_FRAME_SYNC_LINE(fo), .O_FRAME_SYNC_LINE_OE(foe));
    bsc_radio_model i_radio (
        .i_clk(clk), .i_car(car), .i_pa_float(paf), .i_rem_aud(rau), .i_lock_ok(lok),
        .i_ld(ld), .o_st(st), .o_rx_word(rxw), .o_rx_cnt(rxc), .o_en_cyc(enc));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] m, input logic [32:0] g);
        n_tests++;
        if ((g & m) !== (e & m)) begin
            error_cnt++;
            $display("CHECK FAILED apb read exp %h got %h", e & m, g & m);
        end
    endtask : cmp_rd
    task automatic cmp_pin(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : cmp_pin
    // Setup, then access held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        int k;
        @(posedge clk);
        psel  <= 1'b1;
        pwr   <= w;
        paddr <= a;
        pwd   <= d;
        if (!w) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rdy !== 1'b1 && k < 16);
        psel <= 1'b0;
        pen  <= 1'b0;
        if (k == 16) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, 33'h0);
    endtask : wr
    // Error flag always judged with the data
    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        apb(1'b0, a, 32'h0, e, m | 33'h100000000);
    endtask : rd
    task automatic wait_en(input logic v);
        int k;
        for (k = 0; k < 2000 && ld.freq_loader_enable !== v; k++) begin
            @(posedge clk);
        end
        if (k == 2000) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : wait_en
    // Read results judged against the oldest note
    always @(posedge clk) begin
        if (psel && pen && rdy === 1'b1 && !pwr && exp_q.size() > 0) begin
            cmp_rd(exp_q.pop_front(), msk_q.pop_front(), {err, prd});
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cmp_pin("keyups", 32'h3, {rem_n, loc_n});
        cmp_pin("mute", 32'h0, mute_n);
        // Keying, routing, limiter and Walsh levels; last pass unmuted
        for (int i = 3; i >= 0; i--) begin
            c = {$random(seed)} & 32'h300 | 32'h10 | i | (i << 2);
            wr(CTRL_OFS, c);
            repeat (6) @(posedge clk);
            cmp_pin("keyups", {30'h0, ~c[1:0]}, {rem_n, loc_n});
            cmp_pin("hs_lim", c[3:2], {lim, hs});
            cmp_pin("walsh", c[9:8], walsh);
            cmp_pin("mute", !(c[2] && c[1:0] != 2'b00), mute_n);
        end
        car <= 1'b0;
        rau <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_pin("mute", 32'h0, mute_n);
        rd(STATUS_OFS, 32'hC, 32'hF);
        $display("controls done");
        // Good load of 8 bits, then 32 bits that fail to lock
        word = $random(seed);
        for (int j = 0; j < 2; j++) begin
            n = j ? 32 : 8;
            lok <= !j;
            wr(STATUS_OFS, 32'h3C0);
            wr(WORD_OFS, word);
            wr(CMD_OFS, n << CMD_LEN_LO | 1);
            wait_en(1'b1);
            wait_en(1'b0);
            repeat (H + 3) @(posedge clk);
            cmp_pin("bits", n, rxc);
            cmp_pin("data", word & (32'hFFFFFFFF >> (32 - n)), rxw >> (32 - n));
            cmp_pin("en_len", H * (2 * n + 1), enc);
            rd(STATUS_OFS, j ? 32'h80 : 32'h40, 32'hE0);
        end
        lok <= 1'b1;
        repeat (4) @(posedge clk);
        wr(STATUS_OFS, 32'h3C0);
        rd(STATUS_OFS, 32'h0, 32'h100);
        lok <= 1'b0;
        repeat (4) @(posedge clk);
        rd(STATUS_OFS, 32'h100, 32'h100);
        lok <= 1'b1;
        $display("loader done");
        // Mode policy and frame-sync role
        wr(MODE_OFS, 32'h39);
        repeat (3) @(posedge clk);
        cmp_pin("mode", 32'h1, mode);
        wr(CTRL_OFS, 32'hB0);
        repeat (3) @(posedge clk);
        cmp_pin("fsl_oe", 32'h0, foe);
        car <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_pin("mode", 32'h2, mode);
        paf <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_pin("mode", 32'h3, mode);
        rd(STATUS_OFS, 32'h202, 32'h202);
        wr(CTRL_OFS, 32'h10);
        pull <= 1'b1;
        car  <= 1'b0;
        repeat (6) @(posedge clk);
        car <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_pin("mode", 32'h3, mode);
        cmp_pin("fsl_oe", 32'h1, foe);
        rd(STATUS_OFS, 32'h0, 32'h10);
        $display("mode done");
        // Converter code and an unmapped place
        adc <= 8'($random(seed));
        repeat (4) @(posedge clk);
        rd(ADC_OFS, adc, 32'hFF);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, 33'h100000000, 32'hFFFFFFFF);
        $display("misc done");
        report_and_stop();
    end
endmodule : test_base_station_control_io
